// ===== sarro_bench.sv
/*
 Bench joining converter and host ends over one link.
 Assumes package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
module sarro_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic start = 1'b0;
   logic daisy = 1'b0;
   logic [15:0] pos = 16'h0000;
   logic [15:0] neg = 16'h0000;
   logic converting, cs_mode, busy, data_valid;
   logic [15:0] data;
   int n_fail = 0;
   int compares = 0;
   always #10 clk = ~clk;
   sarro_if lnk ();
   sarro_dev sarro_dev_i (.clk(clk), .rst(rst), .ce(ce), .lnk(lnk), .analog_pos_input(pos),
      .analog_neg_input(neg), .converting(converting), .cs_mode(cs_mode));
   sarro_host sarro_host_i (.clk(clk), .rst(rst), .ce(ce), .lnk(lnk), .start(start),
      .daisy(daisy), .busy(busy), .data(data), .data_valid(data_valid));
   sarro_monitor sarro_monitor_i (.clk(clk), .rst(rst),
      .conversion_trigger(lnk.conversion_trigger), .sclk(lnk.sclk), .sdi(lnk.sdi),
      .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe));
   // ------------------------------------------------
   // Compare and report
   // ------------------------------------------------
   task automatic mismatch(input string m);
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) mismatch("result word");
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) mismatch("mode flag");
   endtask
   task automatic chk_span(input int n, input int lo, input int hi);
      compares++;
      if (n < lo || n > hi) mismatch("conversion length");
   endtask
   task automatic final_report;
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------
   // One conversion and readout
   // ------------------------------------------------
   task automatic convert(input logic dz, input logic [15:0] p, input logic [15:0] n);
      int i;
      int cyc;
      logic [15:0] exp;
      // Negative difference clamps to zero
      exp = (p > n) ? p - n : 16'h0000;
      cyc = 0;
      for (i = 0; i < 400 && busy !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      if (busy !== 1'b0) begin
         mismatch("host stuck busy");
         final_report();
      end
      @(posedge clk);
      pos <= p;
      neg <= n;
      daisy <= dz;
      start <= 1'b1;
      for (i = 0; i < 20 && busy !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (busy !== 1'b1) begin
         mismatch("host did not start");
         final_report();
      end
      @(posedge clk);
      start <= 1'b0;
      for (i = 0; i < 3000 && data_valid !== 1'b1; i++) begin
         @(posedge clk);
         // Freeze both ends briefly mid-readout; the word must survive
         ce <= (i < 100 || i > 104);
         #1;
         if (converting === 1'b1) cyc++;
      end
      if (data_valid !== 1'b1) begin
         mismatch("no result word");
         final_report();
      end
      chk_word(data, exp);
      chk_bit(cs_mode, ~dz);
      chk_span(cyc, sarro_pkg::CONV_MIN_CYC, sarro_pkg::CONV_MAX_CYC);
   endtask
   // ------------------------------------------------
   // Sequence: both modes, full scale, clamp, back to back
   // ------------------------------------------------
   logic [15:0] tp [5] = '{16'h1234, 16'hFFFF, 16'h8000, 16'h0005, 16'hA5C3};
   logic [15:0] tn [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0009, 16'h0003};
   logic td [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         convert(td[k], tp[k], tn[k]);
         $display("test %0d done", k);
      end
      final_report();
   end
endmodule

// ===== sarro_dev.sv
/*
 Converter end: conversion sequencing and serial readout in chip
 select and daisy-chain modes. Assumes link pins are asynchronous
 and the analog result arrives as a sampled digital word.
*/
// Summary of operation
// (RULE_01) Trigger rise tristates output, samples, converts
// (RULE_02) Capture positive minus negative input
// (RULE_03) Internal timer, 500 to 1300 ns
// (RULE_04) Acquisition follows; host respects spacing
// (RULE_05) Result readable only in acquisition
// (RULE_06) Select fall drives out MSB
// (RULE_07) Release after select high or last bit
// (RULE_08) Host holds select high at trigger
// (RULE_09) Host keeps select high pulses 10 ns
// (RULE_10) Select high at trigger means chip select
// (RULE_11) Host holds input low for daisy-chain
// (RULE_12) Host keeps serial clock steady at trigger
// (RULE_13) Daisy chain shifts input on falling edges
// (RULE_14) Readout clocked by external serial clock
// (RULE_15) Shift bits on falls, release after 16
// (RULE_16) Result is unsigned straight binary
// (RULE_17) Host waits maximum conversion before reading
`timescale 1ns/1ps
module sarro_dev #(
   parameter int CONV_CYC = sarro_pkg::CONV_MAX_CYC,
   parameter int W = sarro_pkg::RESULT_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   sarro_if.dev lnk,
   input wire logic [W-1:0] analog_pos_input,
   input wire logic [W-1:0] analog_neg_input,
   output logic converting,
   output logic cs_mode
);
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Edge of a synchronised pin, by direction
   function automatic logic pin_edge(input logic now_v, input logic was_v, input logic up);
      pin_edge = up ? (now_v & ~was_v) : (~now_v & was_v);
   endfunction
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [1:0] trg_s_r;
   logic [1:0] sck_s_r;
   logic [1:0] sdi_s_r;
   logic trg_d_r;
   logic sck_d_r;
   logic sdi_d_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trg_s_r <= 2'h0;
         sck_s_r <= 2'h0;
         // Select idles high; a low reset would fake an edge
         sdi_s_r <= 2'h3;
         trg_d_r <= 1'b0;
         sck_d_r <= 1'b0;
         sdi_d_r <= 1'b1;
      end else if (ce) begin
         trg_s_r <= {trg_s_r[0], lnk.conversion_trigger};
         sck_s_r <= {sck_s_r[0], lnk.sclk};
         sdi_s_r <= {sdi_s_r[0], lnk.sdi};
         trg_d_r <= trg_s_r[1];
         sck_d_r <= sck_s_r[1];
         sdi_d_r <= sdi_s_r[1];
      end
   end
   wire trg_rise = pin_edge(trg_s_r[1], trg_d_r, 1'b1);
   wire sck_fall = pin_edge(sck_s_r[1], sck_d_r, 1'b0);
   wire sel_fall = pin_edge(sdi_s_r[1], sdi_d_r, 1'b0);
   wire sel_rise = pin_edge(sdi_s_r[1], sdi_d_r, 1'b1);
   // -------------------------------------------------------------
   // Conversion sequencer
   // -------------------------------------------------------------
   typedef enum logic [1:0] {ST_CONV = 2'b01, ST_ACQ = 2'b10} sarro_st_e;
   sarro_st_e st_r;
   logic [15:0] tmr_r;
   logic [W-1:0] conv_r;
   logic [W:0] diff;
   assign diff = {1'b0, analog_pos_input} - {1'b0, analog_neg_input};
   // Negative difference clamps to zero code
   wire [W-1:0] code = diff[W] ? '0 : diff[W-1:0]; // RULE_16
   wire conv_done = (st_r == ST_CONV) && (tmr_r == 16'(CONV_CYC - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_ACQ;
         tmr_r <= 16'h0000;
         conv_r <= '0;
         cs_mode <= 1'b0;
         converting <= 1'b0;
      end else if (ce) begin
         case (st_r)
            ST_ACQ: begin
               if (trg_rise) begin
                  st_r <= ST_CONV; // RULE_01
                  conv_r <= code; // RULE_02
                  cs_mode <= sdi_s_r[1]; // RULE_10
                  tmr_r <= 16'h0000;
                  converting <= 1'b1;
               end
            end
            ST_CONV: begin
               tmr_r <= tmr_r + 16'h0001; // RULE_03
               if (conv_done) begin
                  st_r <= ST_ACQ; // RULE_04
                  converting <= 1'b0;
               end
            end
            default: st_r <= ST_ACQ;
         endcase
      end
   end
   // -------------------------------------------------------------
   // Two-entry result buffer
   // -------------------------------------------------------------
   // Result queued, but the shifter takes it at once; a word not read out before the next trigger is lost
   logic [W-1:0] buf_r [2];
   logic [1:0] cnt_r;
   logic rd_r;
   logic wr_r;
   wire buf_in_ready = (cnt_r != 2'h2);
   wire buf_in_valid = conv_done;
   wire buf_out_valid = (cnt_r != 2'h0);
   logic buf_out_ready;
   // Full buffer drops the newest result
   wire push = buf_in_valid & buf_in_ready;
   wire pop = buf_out_valid & buf_out_ready;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         cnt_r <= 2'h0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
      end else if (ce) begin
         if (push) begin
            buf_r[wr_r] <= conv_r;
            wr_r <= ~wr_r;
         end
         if (pop) begin
            rd_r <= ~rd_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
   // -------------------------------------------------------------
   // Serial shifter
   // -------------------------------------------------------------
   logic [W-1:0] sh_r;
   logic [4:0] bits_r;
   logic oe_r;
   logic out_r;
   logic loaded_r;
   wire in_acq = (st_r == ST_ACQ);
   // A new word loads only if the last one was shifted out or retired by a trigger
   wire load = in_acq & buf_out_valid & ~loaded_r; // RULE_05
   assign buf_out_ready = load;
   wire last = (bits_r == 5'(W - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sh_r <= sarro_pkg::RESULT_RESET;
         bits_r <= 5'h00;
         oe_r <= 1'b0;
         out_r <= 1'b0;
         loaded_r <= 1'b0;
      end else if (ce) begin
         if (trg_rise) begin
            oe_r <= 1'b0; // RULE_01
            bits_r <= 5'h00;
            // Deselect can hide the last fall; a new conversion retires the word
            loaded_r <= 1'b0;
         end else if (load) begin
            sh_r <= buf_r[rd_r];
            loaded_r <= 1'b1;
            bits_r <= 5'h00;
            if (!cs_mode) begin
               oe_r <= 1'b1;
               out_r <= buf_r[rd_r][W-1];
            end
         end else if (cs_mode & loaded_r & sel_rise) begin
            oe_r <= 1'b0; // RULE_07
         end else if (cs_mode & loaded_r & sel_fall & in_acq) begin
            oe_r <= 1'b1; // RULE_06
            out_r <= sh_r[W-1];
         end else if (loaded_r & sck_fall & in_acq & (oe_r | ~cs_mode)) begin
            // RULE_14
            sh_r <= {sh_r[W-2:0], sdi_s_r[1]}; // RULE_13
            out_r <= sh_r[W-2]; // RULE_15
            bits_r <= bits_r + 5'h01;
            if (last) begin
               loaded_r <= 1'b0;
               if (cs_mode) begin
                  oe_r <= 1'b0; // RULE_15
               end else begin
                  out_r <= sdi_s_r[1];
               end
            end
         end
      end
   end
   // -------------------------------------------------------------
   // Link outputs
   // -------------------------------------------------------------
   assign lnk.sdo = out_r;
   assign lnk.sdo_oe = oe_r;
endmodule

// ===== sarro_host.sv
/*
 Host end: triggers conversions, selects in four-wire mode and
 clocks out one result word. Makes the serial clock by division.
*/
`timescale 1ns/1ps
module sarro_host #(
   parameter int W = sarro_pkg::RESULT_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   sarro_if.host lnk,
   input wire logic start,
   input wire logic daisy,
   output logic busy,
   output logic [W-1:0] data,
   output logic data_valid
);
   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   typedef enum logic [4:0] {
      H_IDLE = 5'b00001, H_SETUP = 5'b00010, H_WAIT = 5'b00100,
      H_SHIFT = 5'b01000, H_GAP = 5'b10000
   } sarro_hst_e;
   sarro_hst_e st_r;
   logic [15:0] tmr_r;
   logic [4:0] bits_r;
   logic [2:0] half_r;
   logic trg_r, sck_r, sdi_r, daisy_r;
   logic [1:0] sdo_s_r;
   logic [W-1:0] sh_r;
   wire half_end = (half_r == 3'(sarro_pkg::SCLK_HALF_CYC - 1));
   wire [15:0] spacing = 16'(sarro_pkg::CYCLE_MIN_CYC);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo_s_r <= 2'h0;
      end else if (ce) begin
         sdo_s_r <= {sdo_s_r[0], lnk.sdo_wire};
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= H_IDLE;
         tmr_r <= 16'h0000;
         bits_r <= 5'h00;
         half_r <= 3'h0;
         trg_r <= 1'b0;
         sck_r <= 1'b0;
         sdi_r <= 1'b1;
         daisy_r <= 1'b0;
         sh_r <= '0;
         busy <= 1'b0;
         data <= '0;
         data_valid <= 1'b0;
      end else if (ce) begin
         data_valid <= 1'b0;
         tmr_r <= tmr_r + 16'h0001;
         case (st_r)
            H_IDLE: begin
               trg_r <= 1'b0;
               if (start) begin
                  // RULE_08
                  daisy_r <= daisy;
                  sdi_r <= ~daisy; // RULE_11
                  tmr_r <= 16'h0000;
                  busy <= 1'b1;
                  st_r <= H_SETUP;
               end
            end
            H_SETUP: begin
               // Clock held low around trigger
               if (tmr_r >= 16'(sarro_pkg::SEL_SETUP_CYC + 2)) begin // RULE_12
                  trg_r <= 1'b1;
                  tmr_r <= 16'h0000;
                  st_r <= H_WAIT;
               end
            end
            H_WAIT: begin
               if (tmr_r >= 16'(sarro_pkg::CONV_MAX_CYC + 4)) begin // RULE_17
                  if (!daisy_r) begin
                     sdi_r <= 1'b0; // RULE_06
                  end
                  trg_r <= 1'b0;
                  bits_r <= 5'h00;
                  half_r <= 3'h0;
                  st_r <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               half_r <= half_end ? 3'h0 : half_r + 3'h1;
               if (half_end) begin
                  sck_r <= ~sck_r;
                  // Sample at the fall: the synced sdo lags the device's shift
                  if (sck_r) begin
                     sh_r <= {sh_r[W-2:0], sdo_s_r[1]}; // RULE_05
                     bits_r <= bits_r + 5'h01;
                     if (bits_r == 5'(W - 1)) begin
                        sdi_r <= ~daisy_r; // RULE_09
                        st_r <= H_GAP;
                     end
                  end
               end
            end
            H_GAP: begin
               data <= sh_r;
               if (tmr_r >= spacing) begin // RULE_04
                  data_valid <= 1'b1;
                  busy <= 1'b0;
                  st_r <= H_IDLE;
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end
   assign lnk.conversion_trigger = trg_r;
   assign lnk.sclk = sck_r;
   assign lnk.sdi = sdi_r;
endmodule

// ===== sarro_if.sv
/*
 Link between converter and host: trigger, serial clock, serial in,
 tri-state serial out. Assumes the bench joins the two modports.
*/
`timescale 1ns/1ps
interface sarro_if;
   logic conversion_trigger;
   logic sclk;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   // Pulled high when released
   wire sdo_wire = sdo_oe ? sdo : 1'b1;
   modport dev (input conversion_trigger, input sclk, input sdi, output sdo, output sdo_oe);
   modport host (output conversion_trigger, output sclk, output sdi, input sdo_wire,
                 input sdo_oe);
endinterface

// ===== sarro_monitor.sv
/*
 Checker for the readout link: watches trigger, serial clock, select and output.
 Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module sarro_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic conversion_trigger,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   logic trig_q_r;
   logic sclk_q_r;
   logic cs_r;
   logic sdi_q_r;
   logic fresh_r;
   logic [7:0] gap_r;
   logic [4:0] fall_r;
   wire trig_rise = conversion_trigger & ~trig_q_r;
   wire sclk_fall = sclk_q_r & ~sclk;
   wire sdi_fell = sdi_q_r & ~sdi;
   // Gap saturates, so one stale value cannot wrap into a false pass
   wire [7:0] gap_nxt = trig_rise ? 8'h00 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h01);
   wire [4:0] fall_nxt = !sdo_oe ? 5'h00 : (sclk_fall ? fall_r + 5'h01 : fall_r);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_q_r <= 1'b0;
         sclk_q_r <= 1'b0;
         cs_r <= 1'b1;
         sdi_q_r <= 1'b1;
         fresh_r <= 1'b0;
         gap_r <= 8'hFF;
         fall_r <= 5'h00;
      end else begin
         trig_q_r <= conversion_trigger;
         sclk_q_r <= sclk;
         cs_r <= trig_rise ? sdi : cs_r;
         sdi_q_r <= sdi;
         // One select per conversion; a later fall starts a daisy frame
         fresh_r <= trig_rise ? 1'b1 : (sdi_fell ? 1'b0 : fresh_r);
         gap_r <= gap_nxt;
         fall_r <= fall_nxt;
      end
   end
   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence trig_s;
      $rose(conversion_trigger);
   endsequence
   sequence off_s;
      ##[0:5] !sdo_oe;
   endsequence
   trig_off_a: assert property (trig_s |-> off_s)
      else $error("output still driven after trigger");
   conv_quiet_a: assert property (trig_s |-> ##5 (!sdo_oe) [*8])
      else $error("output driven during conversion");
   start_gap_a: assert property (trig_s |-> gap_r >= sarro_pkg::CYCLE_MIN_CYC - 1)
      else $error("triggers too close");
   read_wait_a: assert property (cs_r && $fell(sdi) |-> gap_r >= sarro_pkg::CONV_MAX_CYC)
      else $error("select before conversion end");
   mode_setup_a: assert property (trig_s |-> sdi == $past(sdi) ##1 $stable(sdi))
      else $error("select moved around trigger");
   sclk_still_a: assert property (trig_s |-> $stable(sclk) ##1 $stable(sclk))
      else $error("serial clock moved at trigger");
   sel_drive_a: assert property (cs_r && fresh_r && $fell(sdi) |-> ##[1:6] sdo_oe)
      else $error("output not driven after select");
   desel_off_a: assert property (cs_r && $rose(sdi) |-> off_s)
      else $error("output kept after deselect");
   last_bit_a: assert property (cs_r && fall_r == 5'h10 |-> off_s)
      else $error("output kept after last bit");
   sel_pulse_a: assert property ($rose(sdi) |=> sdi)
      else $error("select high pulse too short");
endmodule

// ===== sarro_pkg.sv
/*
 Constants shared by both ends of the serial readout link.
 Assumes a 50 MHz system clock on both ends.
*/
package sarro_pkg;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int CLK_PERIOD_PS = CLK_PERIOD_NS * 1000;
   localparam int CONV_MIN_NS = 500;
   localparam int CONV_MAX_NS = 1300;
   localparam int ACQ_MIN_NS = 1200;
   localparam int CYCLE_MIN_NS = 2500;
   localparam int SEL_HIGH_MIN_NS = 10;
   localparam int SEL_SETUP_PS = 7500;
   // Least times round up, longest round down
   localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_MIN_CYC = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEL_HIGH_CYC = (SEL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEL_SETUP_CYC = (SEL_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // -------------------------------------------------------------
   // Data
   // -------------------------------------------------------------
   localparam int RESULT_BITS = 16;
   localparam int SCLK_HALF_CYC = 4;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
endpackage
